// [shared/csg_pkg.sv]
package csg_pkg;

  // System clock
  localparam int CLK_PERIOD_NS = 100;

  // APB register indices; byte address is four times the index
  localparam int APB_ADDR_W = 16;
  localparam logic [11:0] IDX_ADC_AND_OSC_CONTROL = 12'h0D1;
  localparam logic [11:0] IDX_CLOCK_CONFIG = 12'h0D2;
  localparam logic [11:0] IDX_CLOCK_STATUS = 12'h0D3;
  localparam logic [APB_ADDR_W-1:0] ADDR_ADC_AND_OSC_CONTROL = {2'h0, IDX_ADC_AND_OSC_CONTROL, 2'h0};
  localparam logic [APB_ADDR_W-1:0] ADDR_CLOCK_CONFIG = {2'h0, IDX_CLOCK_CONFIG, 2'h0};
  localparam logic [APB_ADDR_W-1:0] ADDR_CLOCK_STATUS = {2'h0, IDX_CLOCK_STATUS, 2'h0};

  // Register fields and reset values
  localparam logic [7:0] CTRL_RESET = 8'h40;
  localparam int CTRL_MAIN_CLOCK_DISABLE_BIT = 2;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam int CONFIG_ART_DIV3_BIT = 0;

  // Option byte fields
  localparam int OPT_OSC_TYPE_BIT = 6;
  localparam int OPT_GUARD_ENABLE_BIT = 0;

  // Dividers
  localparam logic [3:0] DIV_TIMER = 4'hC;
  localparam logic [3:0] DIV_CPU = 4'hD;
  localparam logic [3:0] DIV_ART_SLOW = 4'h3;
  localparam logic [3:0] DIV_ART_FAST = 4'h1;

  // Timing: guarded minimum period rounds up, backup period rounds down
  localparam int GUARD_MIN_PERIOD_NS = 200;
  localparam int GUARD_MIN_CYC_I = (GUARD_MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] GUARD_MIN_CYC = 8'(GUARD_MIN_CYC_I < 1 ? 1 : GUARD_MIN_CYC_I);
  localparam int BACKUP_PERIOD_NS = 2000;
  localparam int BACKUP_PERIOD_CYC_I = BACKUP_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [7:0] BACKUP_PERIOD_CYC = 8'(BACKUP_PERIOD_CYC_I < 1 ? 1 : BACKUP_PERIOD_CYC_I);
  localparam logic [2:0] MAIN_GOOD_EDGES = 3'h4;

  // Reset delay in internal clock cycles
  localparam int RESET_DELAY_SHORT = 2048;
  localparam int RESET_DELAY_LONG = 32768;

  typedef enum logic [2:0] {
    SRC_MAIN = 3'b001,
    SRC_BACKUP = 3'b010,
    SRC_RETURN = 3'b100
  } csg_src_t;

  typedef struct packed {
    logic [2:0] spare;
    logic reset_delay_done;
    logic backup_enable;
    logic main_enable;
    logic on_backup;
    logic main_ok;
  } csg_status_t;

endpackage

// [logic/csg_tick_div.sv]
`timescale 1ns/1ps
module csg_tick_div
  import csg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic tick_in,
  input wire logic [3:0] ratio,
  output logic tick_out
);

  logic [3:0] count_reg;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      count_reg <= 4'h0;
    end else if (tick_in) begin
      if (count_reg >= ratio - 4'h1) begin
        count_reg <= 4'h0;
      end else begin
        count_reg <= count_reg + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      tick_out <= 1'b0;
    end else begin
      tick_out <= tick_in && (count_reg >= ratio - 4'h1);
    end
  end

endmodule

// [logic/csg_clock_safeguard.sv]
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
module csg_clock_safeguard
  import csg_pkg::*;
#(
  parameter int RESET_DELAY_SHORT_CYC = RESET_DELAY_SHORT,
  parameter int RESET_DELAY_LONG_CYC = RESET_DELAY_LONG
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic crystal_input_pin,
  input wire logic [7:0] option_lsb,
  input wire logic reset_delay_long,
  input wire logic instr_boundary,
  output logic main_osc_enable,
  output logic osc_rc_mode,
  output logic backup_slow_clock_enable,
  output logic core_tick,
  output logic timer_tick,
  output logic cpu_tick,
  output logic autoreload_timer_tick,
  output logic reset_delay_done,
  output logic [7:0] adc_control
);

  logic main_meta_reg;
  logic main_sync_reg;
  logic main_prev_reg;
  logic [8:0] opt_meta_reg;
  logic [8:0] opt_sync_reg;
  logic [7:0] adc_and_osc_control_reg;
  logic [7:0] clock_config_reg;
  logic [7:0] since_accept_reg;
  logic [7:0] since_edge_reg;
  logic [2:0] good_edges_reg;
  logic main_ok_reg;
  logic [7:0] backup_count_reg;
  logic backup_tick;
  csg_src_t src_reg;
  csg_src_t src_next;
  logic [15:0] delay_count_reg;
  logic core_tick_reg;
  logic reset_done_reg;
  logic [31:0] prdata_reg;
  logic guard_on;
  logic disable_bit;
  logic main_edge;
  logic accepted_edge;
  logic main_missing;
  logic backup_on;
  logic setup_phase;
  logic access_phase;
  logic addr_hit;
  logic [15:0] delay_limit;
  logic [3:0] art_ratio;
  csg_status_t status;

  // Pin and option synchronisers
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      main_meta_reg <= 1'b0;
      main_sync_reg <= 1'b0;
      main_prev_reg <= 1'b0;
    end else begin
      main_meta_reg <= crystal_input_pin;
      main_sync_reg <= main_meta_reg;
      main_prev_reg <= main_sync_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      opt_meta_reg <= 9'h000;
      opt_sync_reg <= 9'h000;
    end else begin
      opt_meta_reg <= {reset_delay_long, option_lsb};
      opt_sync_reg <= opt_meta_reg;
    end
  end

  assign guard_on = opt_sync_reg[OPT_GUARD_ENABLE_BIT];
  assign osc_rc_mode = opt_sync_reg[OPT_OSC_TYPE_BIT];
  assign disable_bit = adc_and_osc_control_reg[CTRL_MAIN_CLOCK_DISABLE_BIT];
  assign main_osc_enable = !(guard_on && disable_bit);
  assign main_edge = main_sync_reg && !main_prev_reg;

  // Spike filter: edges closer than the guarded minimum period are dropped
  assign accepted_edge = main_edge && main_osc_enable &&
                         (!guard_on || since_accept_reg >= GUARD_MIN_CYC);

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      since_accept_reg <= 8'h00;
    end else if (accepted_edge) begin
      since_accept_reg <= 8'h01;
    end else if (since_accept_reg != 8'hFF) begin
      since_accept_reg <= since_accept_reg + 8'h01;
    end
  end

  // Missing-edge watch: a full backup period without a main edge
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      since_edge_reg <= 8'h00;
    end else if (main_edge && main_osc_enable) begin
      since_edge_reg <= 8'h00;
    end else if (since_edge_reg != 8'hFF) begin
      since_edge_reg <= since_edge_reg + 8'h01;
    end
  end

  assign main_missing = since_edge_reg >= BACKUP_PERIOD_CYC;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      good_edges_reg <= 3'h0;
      main_ok_reg <= 1'b0;
    end else if (main_missing || !main_osc_enable) begin
      good_edges_reg <= 3'h0;
      main_ok_reg <= 1'b0;
    end else if (accepted_edge && !main_ok_reg) begin
      if (good_edges_reg >= MAIN_GOOD_EDGES - 3'h1) begin
        main_ok_reg <= 1'b1;
      end else begin
        good_edges_reg <= good_edges_reg + 3'h1;
      end
    end
  end

  // Backup oscillator runs only with the guard and while main is not running
  assign backup_on = guard_on && !main_ok_reg;
  assign backup_slow_clock_enable = backup_on;
  assign backup_tick = backup_on && (backup_count_reg >= BACKUP_PERIOD_CYC - 8'h01);

  // Restart from zero on every switch so the first backup tick is a full period away
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      backup_count_reg <= 8'h00;
    end else if (!backup_on || backup_tick || (src_reg == SRC_MAIN)) begin
      backup_count_reg <= 8'h00;
    end else begin
      backup_count_reg <= backup_count_reg + 8'h01;
    end
  end

  // Source selection
  always_comb begin
    src_next = src_reg;
    unique case (src_reg)
      SRC_MAIN: begin
        if (guard_on && !main_ok_reg) begin
          src_next = SRC_BACKUP;
        end
      end
      SRC_BACKUP: begin
        if (!guard_on) begin
          src_next = SRC_MAIN;
        end else if (main_ok_reg) begin
          src_next = SRC_RETURN;
        end
      end
      SRC_RETURN: begin
        if (!guard_on) begin
          src_next = SRC_MAIN;
        end else if (!main_ok_reg) begin
          src_next = SRC_BACKUP;
        end else if (instr_boundary) begin
          src_next = SRC_MAIN;
        end
      end
      default: begin
        src_next = SRC_MAIN;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      src_reg <= SRC_MAIN;
    end else begin
      src_reg <= src_next;
    end
  end

  // Core clock tick from one source only; CPU runs at backup rate in SRC_BACKUP and gets no ticks in SRC_RETURN
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      core_tick_reg <= 1'b0;
    end else if (src_reg == SRC_MAIN) begin
      core_tick_reg <= accepted_edge;
    end else begin
      core_tick_reg <= backup_tick;
    end
  end

  assign core_tick = core_tick_reg;

  // Reset delay counts whichever source drives the core
  assign delay_limit = opt_sync_reg[8] ? 16'(RESET_DELAY_LONG_CYC - 1) :
                                         16'(RESET_DELAY_SHORT_CYC - 1);

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      delay_count_reg <= 16'h0000;
      reset_done_reg <= 1'b0;
    end else if (core_tick_reg && !reset_done_reg) begin
      if (delay_count_reg >= delay_limit) begin
        reset_done_reg <= 1'b1;
      end else begin
        delay_count_reg <= delay_count_reg + 16'h0001;
      end
    end
  end

  assign reset_delay_done = reset_done_reg;

  // Peripheral clock dividers
  csg_tick_div u_timer_div (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .tick_in(core_tick_reg),
    .ratio(DIV_TIMER),
    .tick_out(timer_tick)
  );

  csg_tick_div u_cpu_div (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .tick_in(core_tick_reg),
    .ratio(DIV_CPU),
    .tick_out(cpu_tick)
  );

  assign art_ratio = clock_config_reg[CONFIG_ART_DIV3_BIT] ? DIV_ART_SLOW : DIV_ART_FAST;

  csg_tick_div u_art_div (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .tick_in(core_tick_reg),
    .ratio(art_ratio),
    .tick_out(autoreload_timer_tick)
  );

  // APB slave, zero wait states
  assign setup_phase = psel && !penable;
  assign access_phase = psel && penable;
  assign addr_hit = (paddr == ADDR_ADC_AND_OSC_CONTROL) || (paddr == ADDR_CLOCK_CONFIG) ||
                    (paddr == ADDR_CLOCK_STATUS);
  assign pready = 1'b1;
  assign pslverr = access_phase && !addr_hit;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      adc_and_osc_control_reg <= CTRL_RESET;
    end else if (access_phase && pwrite && paddr == ADDR_ADC_AND_OSC_CONTROL) begin
      adc_and_osc_control_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      clock_config_reg <= CONFIG_RESET;
    end else if (access_phase && pwrite && paddr == ADDR_CLOCK_CONFIG) begin
      clock_config_reg <= pwdata[7:0];
    end
  end

  assign status = '{spare: 3'h0, reset_delay_done: reset_done_reg,
                    backup_enable: backup_on, main_enable: main_osc_enable,
                    on_backup: (src_reg != SRC_MAIN), main_ok: main_ok_reg};

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      prdata_reg <= 32'h00000000;
    end else if (setup_phase) begin
      if (paddr == ADDR_ADC_AND_OSC_CONTROL) begin
        prdata_reg <= {24'h000000, adc_and_osc_control_reg};
      end else if (paddr == ADDR_CLOCK_CONFIG) begin
        prdata_reg <= {24'h000000, clock_config_reg};
      end else if (paddr == ADDR_CLOCK_STATUS) begin
        prdata_reg <= {24'h000000, status};
      end else begin
        prdata_reg <= 32'h00000000;
      end
    end
  end

  assign prdata = prdata_reg;

  // ADC bits pass to the converter; bit 2 belongs to the oscillator
  assign adc_control = adc_and_osc_control_reg & ~(8'h01 << CTRL_MAIN_CLOCK_DISABLE_BIT);

endmodule

// [verification/csg_clock_safeguard_sva.sv]
`timescale 1ns/1ps
module csg_clock_safeguard_sva
  import csg_pkg::*;
#(
  parameter int RESET_DELAY_SHORT_CYC = RESET_DELAY_SHORT,
  parameter int RESET_DELAY_LONG_CYC = RESET_DELAY_LONG
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic [APB_ADDR_W-1:0] paddr,
  input wire logic pslverr,
  input wire logic [7:0] option_lsb,
  input wire logic reset_delay_long,
  input wire logic main_osc_enable,
  input wire logic osc_rc_mode,
  input wire logic backup_slow_clock_enable,
  input wire logic core_tick,
  input wire logic timer_tick,
  input wire logic cpu_tick,
  input wire logic reset_delay_done
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  logic core_d, tseen, cseen, mapped;
  int tcnt, ccnt, rcnt, dly;
  assign dly = reset_delay_long ? RESET_DELAY_LONG_CYC : RESET_DELAY_SHORT_CYC;
  assign mapped = paddr inside {ADDR_ADC_AND_OSC_CONTROL, ADDR_CLOCK_CONFIG, ADDR_CLOCK_STATUS};
  // Core ticks seen between divider pulses and since reset
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      core_d <= 1'b0;
      tseen <= 1'b0;
      cseen <= 1'b0;
      tcnt <= 0;
      ccnt <= 0;
      rcnt <= 0;
    end else begin
      core_d <= core_tick;
      tseen <= tseen | timer_tick;
      cseen <= cseen | cpu_tick;
      tcnt <= timer_tick ? 0 : tcnt + int'(core_d);
      ccnt <= cpu_tick ? 0 : ccnt + int'(core_d);
      rcnt <= rcnt + int'(core_tick);
    end
  end
  sequence main_off;
    $fell(main_osc_enable);
  endsequence
  sequence backup_up;
    ##[1:40] backup_slow_clock_enable;
  endsequence
  timer_period_a: assert property (timer_tick && tseen |-> tcnt == 11)
    else $error("timer tick spacing wrong");
  cpu_period_a: assert property (cpu_tick && cseen |-> ccnt == 12)
    else $error("cpu tick spacing wrong");
  slverr_map_a: assert property (psel && penable |-> pslverr != mapped)
    else $error("slave error flag wrong");
  backup_start_a: assert property (main_off |-> backup_up)
    else $error("backup clock late");
  backup_stop_a: assert property ($rose(main_osc_enable) |-> ##[1:300] !backup_slow_clock_enable)
    else $error("backup clock not stopped");
  backup_guard_a: assert property (backup_slow_clock_enable |-> $past(option_lsb[0], 2))
    else $error("backup clock without guard");
  disable_guard_a: assert property (!main_osc_enable |-> $past(option_lsb[0], 2))
    else $error("main clock off without guard");
  guard_space_a: assert property (core_tick && $past(option_lsb[0], 2) |=> !core_tick)
    else $error("guarded clock too fast");
  rc_mode_a: assert property ($past(reset_n, 3) |-> osc_rc_mode == $past(option_lsb[6], 2))
    else $error("oscillator mode wrong");
  delay_done_a: assert property ($rose(reset_delay_done) |-> rcnt >= dly - 1 && rcnt <= dly + 2)
    else $error("reset delay length wrong");
endmodule
bind csg_clock_safeguard csg_clock_safeguard_sva #(
  .RESET_DELAY_SHORT_CYC(RESET_DELAY_SHORT_CYC),
  .RESET_DELAY_LONG_CYC(RESET_DELAY_LONG_CYC)
) sva_i (
  .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable), .paddr(paddr),
  .pslverr(pslverr), .option_lsb(option_lsb), .reset_delay_long(reset_delay_long),
  .main_osc_enable(main_osc_enable), .osc_rc_mode(osc_rc_mode),
  .backup_slow_clock_enable(backup_slow_clock_enable), .core_tick(core_tick),
  .timer_tick(timer_tick), .cpu_tick(cpu_tick), .reset_delay_done(reset_delay_done)
);

// [verification/csg_osc_model.sv]
`timescale 1ns/1ps
module csg_osc_model #(
  parameter int HALF_NS = 250
) (
  input wire logic run,
  input wire logic osc_en,
  output logic crystal_input_pin
);
  initial begin
    crystal_input_pin = 1'b0;
    // Offset keeps pin edges away from clock edges
    #25;
    forever begin
      if (run && osc_en) begin
        #(HALF_NS) crystal_input_pin = ~crystal_input_pin;
      end else begin
        crystal_input_pin = 1'b0;
        #(50);
      end
    end
  end
endmodule

// [verification/csg_clock_safeguard_tb.sv]
`timescale 1ns/1ps
module csg_clock_safeguard_tb
  import csg_pkg::*;
;
  logic clk_sys, reset_n, psel, penable, pwrite, pready, pslverr, xtal, rlong, ib, run;
  logic moe, rcm, bk, core_tick, timer_tick, cpu_tick, art, done;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic [7:0] opt, adc;
  logic [33:0] e, q[$];
  int error_cnt, checks, cyc, k, cnt[4], dl[4];
  integer seed = 32'he96f00b5;
  csg_clock_safeguard #(.RESET_DELAY_SHORT_CYC(16), .RESET_DELAY_LONG_CYC(64)) uut (
    .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .crystal_input_pin(xtal), .option_lsb(opt), .reset_delay_long(rlong), .instr_boundary(ib),
    .main_osc_enable(moe), .osc_rc_mode(rcm), .backup_slow_clock_enable(bk),
    .core_tick(core_tick), .timer_tick(timer_tick), .cpu_tick(cpu_tick),
    .autoreload_timer_tick(art), .reset_delay_done(done), .adc_control(adc));
  csg_osc_model osc (.run(run), .osc_en(moe), .crystal_input_pin(xtal));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic report_and_stop;
    if (error_cnt == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  function automatic logic near(int a, int b, int t);
    return a - b <= t && b - a <= t;
  endfunction
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] x, input logic er);
    q.push_back({~w, er, x});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= x;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wait_bk(input logic v, input int n);
    for (int i = 0; i < n && bk !== v; i++) @(posedge clk_sys);
    chk("backup_en", bk, v);
  endtask
  task automatic meas(input int n);
    dl = cnt;
    repeat (n) @(posedge clk_sys);
    foreach (dl[i]) dl[i] = cnt[i] - dl[i];
  endtask
  task automatic do_rst;
    reset_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    ib <= (cyc % 5) == 0;
    cnt <= '{cnt[0] + core_tick, cnt[1] + art, cnt[2] + timer_tick, cnt[3] + cpu_tick};
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop;
    end
  end
  always @(posedge clk_sys) begin
    if (psel && penable && pready) begin
      e = q.pop_front();
      chk("pslverr", pslverr, e[32]);
      if (e[33]) chk("prdata", prdata, e[31:0]);
    end
  end
  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0;
    pwdata = 32'h0;
    run = 1'b1;
    rlong = 1'b0;
    ib = 1'b0;
    opt = 8'h41;
    cyc = 0;
    cnt = '{0, 0, 0, 0};
    do_rst;
    apb(1'b0, ADDR_ADC_AND_OSC_CONTROL, {24'h0, CTRL_RESET}, 1'b0);
    apb(1'b0, ADDR_CLOCK_CONFIG, {24'h0, CONFIG_RESET}, 1'b0);
    chk("rc_mode", rcm, 1'b1);
    d = {24'h0, 8'($random(seed))} & 32'hFB;
    apb(1'b1, ADDR_ADC_AND_OSC_CONTROL, d, 1'b0);
    chk("adc_ctrl", adc, d[7:0]);
    apb(1'b1, 16'h0350, 32'hFF, 1'b1);
    apb(1'b0, 16'h0350, 32'h0, 1'b1);
    apb(1'b0, ADDR_ADC_AND_OSC_CONTROL, d, 1'b0);
    // Let the main clock be detected and selected before rates are measured
    repeat (40) @(posedge clk_sys);
    for (k = 0; k < 2; k++) begin
      apb(1'b1, ADDR_CLOCK_CONFIG, k, 1'b0);
      meas(600);
      chk("core_rate", near(dl[0], 120, 3), 1'b1);
      chk("art_ratio", near(dl[0], dl[1] * (k ? 3 : 1), 3), 1'b1);
      chk("timer_ratio", near(dl[0], dl[2] * 12, 12), 1'b1);
      chk("cpu_ratio", near(dl[0], dl[3] * 13, 13), 1'b1);
    end
    apb(1'b1, ADDR_ADC_AND_OSC_CONTROL, 32'h44, 1'b0);
    chk("main_en", moe, 1'b0);
    chk("adc_ctrl", adc, 8'h40);
    wait_bk(1'b1, 40);
    meas(400);
    chk("backup_rate", near(dl[0], 400 / int'(BACKUP_PERIOD_CYC), 2), 1'b1);
    apb(1'b1, ADDR_ADC_AND_OSC_CONTROL, 32'h40, 1'b0);
    wait_bk(1'b0, 200);
    run <= 1'b0;
    wait_bk(1'b1, 60);
    run <= 1'b1;
    wait_bk(1'b0, 200);
    rlong <= 1'b1;
    run <= 1'b0;
    do_rst;
    repeat (300) @(posedge clk_sys);
    chk("backup_en", bk, 1'b1);
    chk("delay_done", done, 1'b0);
    run <= 1'b1;
    for (k = 0; k < 2000 && done !== 1'b1; k++) @(posedge clk_sys);
    chk("delay_done", done, 1'b1);
    chk("backup_en", bk, 1'b0);
    opt <= 8'h00;
    rlong <= 1'b0;
    do_rst;
    apb(1'b1, ADDR_ADC_AND_OSC_CONTROL, 32'h44, 1'b0);
    chk("main_en", moe, 1'b1);
    apb(1'b0, ADDR_ADC_AND_OSC_CONTROL, 32'h44, 1'b0);
    run <= 1'b0;
    repeat (60) @(posedge clk_sys);
    chk("backup_en", bk, 1'b0);
    chk("rc_mode", rcm, 1'b0);
    report_and_stop;
  end
endmodule
